// ===== design/pidc_pkg.sv
// shared constants, register map and types of the process controller
package pidc_pkg;
	localparam int unsigned CLK_MHZ             = 100;
	localparam int unsigned CTRL_PERIOD_US      = 1000;
	localparam int unsigned CTRL_PERIOD_CYC_DEF = CTRL_PERIOD_US * CLK_MHZ;
	localparam logic [3:0]  SUBTICK_LAST        = 4'h9;
	localparam int unsigned DIV_W               = 28;
	localparam logic [9:0]  PCT_FULL            = 10'h3e8;
	localparam logic [9:0]  AIN_PCT_MUL         = 10'h3e9;
	localparam logic [6:0]  GAIN_DIV            = 7'h64;
	localparam logic [6:0]  TI_SCALE            = 7'h64;
	localparam logic [3:0]  TD_SCALE            = 4'ha;
	localparam logic [3:0]  OGAIN_DIV           = 4'ha;
	localparam logic [7:0]  REG_SRC             = 8'h00;
	localparam logic [7:0]  REG_MODE            = 8'h04;
	localparam logic [7:0]  REG_TARGET          = 8'h08;
	localparam logic [7:0]  REG_KP              = 8'h0c;
	localparam logic [7:0]  REG_TI              = 8'h10;
	localparam logic [7:0]  REG_TD              = 8'h14;
	localparam logic [7:0]  REG_ILIM            = 8'h18;
	localparam logic [7:0]  REG_OLIM            = 8'h1c;
	localparam logic [7:0]  REG_BIAS            = 8'h20;
	localparam logic [7:0]  REG_OGAIN           = 8'h24;
	localparam logic [7:0]  REG_RAMP            = 8'h28;
	localparam logic [7:0]  REG_FMAX            = 8'h2c;
	localparam logic [7:0]  REG_FBGAIN          = 8'h30;
	localparam logic [7:0]  REG_STATUS          = 8'h34;
	localparam logic [7:0]  REG_PIDOUT          = 8'h38;
	localparam logic [7:0]  REG_FREQ            = 8'h3c;
	localparam int unsigned FLD_FB_LSB          = 4;
	localparam int unsigned FLD_PUMP_LSB        = 8;
	localparam int unsigned FLD_REV             = 4;
	localparam int unsigned MODE_EN             = 0;
	localparam int unsigned MODE_NEG            = 1;
	localparam int unsigned MODE_DFB            = 2;
	localparam int unsigned MODE_ADDT           = 3;
	localparam int unsigned ST_ALARM            = 0;
	localparam int unsigned ST_ACTIVE           = 1;
	localparam int unsigned ST_RUN              = 2;
	localparam logic [2:0]  SRC_KEYPAD          = 3'h0;
	localparam logic [2:0]  SRC_AIN1            = 3'h1;
	localparam logic [2:0]  SRC_AIN2            = 3'h2;
	localparam logic [2:0]  SRC_PARAM           = 3'h4;
	localparam logic [1:0]  FB_AIN1             = 2'h1;
	localparam logic [1:0]  FB_AIN2             = 2'h2;
	localparam logic [1:0]  PUMP_A              = 2'h1;
	localparam logic [1:0]  PUMP_B              = 2'h2;

	typedef logic signed [11:0] pidc_pct_t;
	typedef logic signed [17:0] pidc_freq_t;
	typedef logic signed [39:0] pidc_wide_t;
	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_DIV = 3'b010, ST_OUT = 3'b100} pidc_state_t;
	typedef struct packed {
		logic [2:0]         tgt_src;
		logic [1:0]         fb_src;
		logic [1:0]         pump_mode;
		logic [3:0]         mode;
		logic               rev_allow;
		logic [9:0]         target;
		logic [9:0]         kp;
		logic [9:0]         ti;
		logic [9:0]         td;
		logic [9:0]         ilim;
		logic [9:0]         olim;
		logic signed [10:0] bias;
		logic [7:0]         ogain;
		logic [7:0]         ramp;
		logic [15:0]        fmax;
		logic [9:0]         fbgain;
	} pidc_cfg_t;
	localparam pidc_cfg_t CFG_RST = '{tgt_src: 3'h1, fb_src: 2'h2, pump_mode: 2'h0, mode: 4'h0, rev_allow: 1'b0,
		target: 10'h000, kp: 10'h064, ti: 10'h00a, td: 10'h000, ilim: 10'h3e8, olim: 10'h3e8, bias: 11'h000,
		ogain: 8'h0a, ramp: 8'h00, fmax: 16'h1770, fbgain: 10'h064};
endpackage : pidc_pkg

// ===== design/pidc_div_if.sv
// handshake between the controller and its serial divider
`timescale 1ns/1ps
`default_nettype none
interface pidc_div_if #(parameter int unsigned W = 28) ();
	logic         start;
	logic [W-1:0] dividend;
	logic [W-1:0] divisor;
	logic [W-1:0] quotient;
	logic         done;
	modport master (output start, dividend, divisor, input quotient, done);
	modport slave  (input start, dividend, divisor, output quotient, done);
endinterface : pidc_div_if
`default_nettype wire

// ===== design/pidc_div.sv
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module pidc_div #(
	parameter int unsigned W = 28
) (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	pidc_div_if.slave       div
);
	import pidc_pkg::*;

	localparam int unsigned CW = $clog2(W + 1);

	logic          busy, next_busy;
	logic          done, next_done;
	logic [CW-1:0] cnt, next_cnt;
	logic [W:0]    rem, next_rem;
	logic [W-1:0]  quo, next_quo;
	logic [W-1:0]  den, next_den;
	logic [W:0]    shifted;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_busy = busy;
		next_done = 1'b0;
		next_cnt  = cnt;
		next_rem  = rem;
		next_quo  = quo;
		next_den  = den;
		shifted   = {rem[W-1:0], quo[W-1]};
		if (!busy) begin
			if (div.start) begin
				next_busy = 1'b1;
				next_cnt  = CW'(W);
				next_rem  = '0;
				next_quo  = div.dividend;
				next_den  = div.divisor;
			end
		end else begin
			if (shifted >= {1'b0, den}) begin
				next_rem = shifted - {1'b0, den};
				next_quo = {quo[W-2:0], 1'b1};
			end else begin
				next_rem = shifted;
				next_quo = {quo[W-2:0], 1'b0};
			end
			next_cnt = cnt - CW'(1);
			if (cnt == CW'(1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt  <= '0;
			rem  <= '0;
			quo  <= '0;
			den  <= '0;
		end else begin
			busy <= next_busy;
			done <= next_done;
			cnt  <= next_cnt;
			rem  <= next_rem;
			quo  <= next_quo;
			den  <= next_den;
		end
	end

	assign div.done     = done;
	assign div.quotient = quo;
endmodule : pidc_div
`default_nettype wire

// ===== design/pidc_top.sv
// process controller: register slave, setpoint path, ramp and PID core
`timescale 1ns/1ps
`default_nettype none
module pidc_top #(
	parameter int unsigned AIN_W           = 12,
	parameter int unsigned CTRL_PERIOD_CYC = pidc_pkg::CTRL_PERIOD_CYC_DEF
) (
	input  wire logic             clock_i,
	input  wire logic             resetn_i,
	input  wire logic [7:0]       avs_address_i,
	input  wire logic             avs_read_i,
	input  wire logic             avs_write_i,
	input  wire logic [31:0]      avs_writedata_i,
	input  wire logic [3:0]       avs_byteenable_i,
	output logic      [31:0]      avs_readdata_o,
	output logic                  avs_waitrequest_o,
	input  wire logic [AIN_W-1:0] analog_input_one_i,
	input  wire logic [AIN_W-1:0] analog_input_two_i,
	input  wire logic [9:0]       keypad_setpoint_i,
	input  wire logic             drive_run_i,
	output pidc_pkg::pidc_freq_t  freq_ref_o,
	output logic                  source_conflict_alarm_o,
	output logic                  pid_active_o
);
	import pidc_pkg::*;

	if (AIN_W < 4 || AIN_W > 16) begin : g_chk_ain
		$error("AIN_W must lie between 4 and 16");
	end
	if (CTRL_PERIOD_CYC < 100 || CTRL_PERIOD_CYC > 10_000_000 || CTRL_PERIOD_CYC % 10 != 0) begin : g_chk_per
		$error("CTRL_PERIOD_CYC must be a multiple of 10 from 100 to 10000000");
	end

	localparam logic [23:0] SUB_LAST = 24'(CTRL_PERIOD_CYC / 10 - 1);

	////////////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta, rst_n;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge_be

	function automatic logic [9:0] sat10(input logic [31:0] v, input logic [9:0] hi, input logic [9:0] lo);
		if (v > {22'h00_0000, hi}) begin
			return hi;
		end
		if (v < {22'h00_0000, lo}) begin
			return lo;
		end
		return v[9:0];
	endfunction : sat10

	function automatic logic src_clash(input logic [2:0] t, input logic [1:0] f);
		return (t == SRC_AIN1 && f == FB_AIN1) || (t == SRC_AIN2 && f == FB_AIN2);
	endfunction : src_clash

	function automatic pidc_pct_t pct_of(input logic [AIN_W-1:0] a);
		logic [AIN_W+9:0] p;
		p = (AIN_W + 10)'(a) * (AIN_W + 10)'(AIN_PCT_MUL);
		return pidc_pct_t'(p >> AIN_W);
	endfunction : pct_of

	function automatic pidc_wide_t clampw(input pidc_wide_t v, input pidc_wide_t lim);
		if (v > lim) begin
			return lim;
		end
		if (v < -lim) begin
			return -lim;
		end
		return v;
	endfunction : clampw

	////////////////////////////////////////////////////////////////////////////////
	// register slave
	pidc_cfg_t   cfg, next_cfg;
	logic        alarm, next_alarm;
	logic        ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic [31:0] cur_word, wr_word;
	logic [7:0]  addr_w;
	pidc_pct_t   pid_out;
	pidc_freq_t  freq;

	assign addr_w = {avs_address_i[7:2], 2'b00};

	always_comb begin
		cur_word = 32'h0000_0000;
		case (addr_w)
			REG_SRC: begin
				cur_word[2:0]                = cfg.tgt_src;
				cur_word[FLD_FB_LSB +: 2]    = cfg.fb_src;
				cur_word[FLD_PUMP_LSB +: 2]  = cfg.pump_mode;
			end
			REG_MODE: begin
				cur_word[3:0]   = cfg.mode;
				cur_word[FLD_REV] = cfg.rev_allow;
			end
			REG_TARGET: cur_word[9:0] = cfg.target;
			REG_KP:     cur_word[9:0] = cfg.kp;
			REG_TI:     cur_word[9:0] = cfg.ti;
			REG_TD:     cur_word[9:0] = cfg.td;
			REG_ILIM:   cur_word[9:0] = cfg.ilim;
			REG_OLIM:   cur_word[9:0] = cfg.olim;
			REG_BIAS:   cur_word = 32'(cfg.bias);
			REG_OGAIN:  cur_word[7:0] = cfg.ogain;
			REG_RAMP:   cur_word[7:0] = cfg.ramp;
			REG_FMAX:   cur_word[15:0] = cfg.fmax;
			REG_FBGAIN: cur_word[9:0] = cfg.fbgain;
			REG_STATUS: begin
				cur_word[ST_ALARM]  = alarm;
				cur_word[ST_ACTIVE] = cfg.mode[MODE_EN];
				cur_word[ST_RUN]    = drive_run_i;
			end
			REG_PIDOUT: cur_word = 32'(pid_out);
			REG_FREQ:   cur_word = 32'(freq);
			default:    cur_word = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_cfg   = cfg;
		next_alarm = alarm;
		next_ack   = (avs_read_i | avs_write_i) & ~ack;
		next_rdata = rdata;
		wr_word    = merge_be(cur_word, avs_writedata_i, avs_byteenable_i);
		if (avs_read_i && !ack) begin
			next_rdata = cur_word;
		end
		if (avs_write_i && ack) begin
			case (addr_w)
				REG_SRC: begin
					if (src_clash(wr_word[2:0], wr_word[FLD_FB_LSB +: 2])) begin
						next_alarm = 1'b1;
					end else begin
						next_alarm         = 1'b0;
						next_cfg.tgt_src   = wr_word[2:0];
						next_cfg.fb_src    = wr_word[FLD_FB_LSB +: 2];
						next_cfg.pump_mode = wr_word[FLD_PUMP_LSB +: 2];
					end
				end
				REG_MODE: begin
					next_cfg.mode      = wr_word[3:0];
					next_cfg.rev_allow = wr_word[FLD_REV];
				end
				REG_TARGET: next_cfg.target = sat10(wr_word, PCT_FULL, 10'h000);
				REG_KP:     next_cfg.kp     = sat10(wr_word, PCT_FULL, 10'h000);
				REG_TI:     next_cfg.ti     = sat10(wr_word, PCT_FULL, 10'h000);
				REG_TD:     next_cfg.td     = sat10(wr_word, PCT_FULL, 10'h000);
				REG_ILIM:   next_cfg.ilim   = sat10(wr_word, PCT_FULL, 10'h000);
				REG_OLIM:   next_cfg.olim   = sat10(wr_word, PCT_FULL, 10'h000);
				REG_BIAS:   next_cfg.bias   = wr_word[10:0];
				REG_OGAIN:  next_cfg.ogain  = wr_word[7:0];
				REG_RAMP:   next_cfg.ramp   = wr_word[7:0];
				REG_FMAX:   next_cfg.fmax   = wr_word[15:0];
				REG_FBGAIN: next_cfg.fbgain = sat10(wr_word, PCT_FULL, 10'h001);
				default:    next_cfg = cfg;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg   <= CFG_RST;
			alarm <= 1'b0;
			ack   <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			cfg   <= next_cfg;
			alarm <= next_alarm;
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
	assign avs_readdata_o    = rdata;

	////////////////////////////////////////////////////////////////////////////////
	// setpoint and feedback selection
	pidc_pct_t  sp_raw, fb_pct;
	pidc_wide_t fb_scaled;

	always_comb begin
		case (cfg.tgt_src)
			SRC_KEYPAD: begin
				if (cfg.pump_mode == PUMP_A || cfg.pump_mode == PUMP_B) begin
					sp_raw = pidc_pct_t'({2'b00, keypad_setpoint_i});
				end else begin
					sp_raw = '0;
				end
			end
			SRC_AIN1:  sp_raw = pct_of(analog_input_one_i);
			SRC_AIN2:  sp_raw = pct_of(analog_input_two_i);
			SRC_PARAM: sp_raw = pidc_pct_t'({2'b00, cfg.target});
			default:   sp_raw = '0;
		endcase
		case (cfg.fb_src)
			FB_AIN1: fb_scaled = pidc_wide_t'(pct_of(analog_input_one_i));
			FB_AIN2: fb_scaled = pidc_wide_t'(pct_of(analog_input_two_i));
			default: fb_scaled = '0;
		endcase
		fb_scaled = clampw(fb_scaled * pidc_wide_t'(cfg.fbgain) / pidc_wide_t'(GAIN_DIV), pidc_wide_t'(PCT_FULL));
		fb_pct    = pidc_pct_t'(fb_scaled);
	end

	////////////////////////////////////////////////////////////////////////////////
	// control period and setpoint ramp
	logic [23:0] sub_cnt, next_sub_cnt;
	logic [3:0]  dec_cnt, next_dec_cnt;
	logic [7:0]  racc, next_racc;
	pidc_pct_t   sp_ramp, next_sp_ramp;
	logic        sub_tick, tick;

	assign sub_tick = (sub_cnt == 24'h00_0000);
	assign tick     = sub_tick && (dec_cnt == 4'h0);

	always_comb begin
		next_sub_cnt = sub_tick ? SUB_LAST : sub_cnt - 24'h00_0001;
		next_dec_cnt = dec_cnt;
		if (sub_tick) begin
			next_dec_cnt = (dec_cnt == 4'h0) ? SUBTICK_LAST : dec_cnt - 4'h1;
		end
		next_racc    = racc;
		next_sp_ramp = sp_ramp;
		if (cfg.ramp == 8'h00) begin
			next_sp_ramp = sp_raw;
			next_racc    = 8'h00;
		end else if (sub_tick && sp_ramp != sp_raw) begin
			if (racc + 8'h01 >= cfg.ramp) begin
				next_racc    = 8'h00;
				next_sp_ramp = (sp_ramp < sp_raw) ? sp_ramp + 12'sh001 : sp_ramp - 12'sh001;
			end else begin
				next_racc = racc + 8'h01;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sub_cnt <= 24'h00_0000;
			dec_cnt <= 4'h0;
			racc    <= 8'h00;
			sp_ramp <= '0;
		end else begin
			sub_cnt <= next_sub_cnt;
			dec_cnt <= next_dec_cnt;
			racc    <= next_racc;
			sp_ramp <= next_sp_ramp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// PID core
	pidc_div_if #(.W(DIV_W)) div_bus ();

	pidc_div #(
		.W(DIV_W)
	) u_div (
		.clock_i (clock_i),
		.rst_n_i (rst_n),
		.div     (div_bus.slave)
	);

	pidc_state_t       state, next_state;
	pidc_wide_t        acc, next_acc;
	pidc_wide_t        p_term, next_p_term;
	pidc_wide_t        d_term, next_d_term;
	pidc_wide_t        i_term, next_i_term;
	pidc_pct_t         d_prev, next_d_prev;
	pidc_pct_t         next_pid_out;
	pidc_freq_t        next_freq;
	logic              div_start, next_div_start;
	logic              acc_neg, next_acc_neg;
	logic [DIV_W-1:0]  div_num, next_div_num;
	logic [DIV_W-1:0]  div_den, next_div_den;
	pidc_wide_t        err_w, acc_lim, acc_sum, d_in, sum, fref;

	assign div_bus.start    = div_start;
	assign div_bus.dividend = div_num;
	assign div_bus.divisor  = div_den;

	always_comb begin
		next_state     = state;
		next_acc       = acc;
		next_p_term    = p_term;
		next_d_term    = d_term;
		next_i_term    = i_term;
		next_d_prev    = d_prev;
		next_pid_out   = pid_out;
		next_freq      = freq;
		next_div_start = 1'b0;
		next_acc_neg   = acc_neg;
		next_div_num   = div_num;
		next_div_den   = div_den;
		err_w          = pidc_wide_t'(sp_ramp) - pidc_wide_t'(fb_pct);
		acc_lim        = pidc_wide_t'(cfg.ilim) * pidc_wide_t'(cfg.ti) * pidc_wide_t'(TI_SCALE);
		acc_sum        = acc + err_w;
		d_in           = cfg.mode[MODE_DFB] ? -pidc_wide_t'(fb_pct) : err_w;
		sum            = p_term + i_term + d_term;
		fref           = '0;
		if (!cfg.mode[MODE_EN]) begin
			next_state   = ST_IDLE;
			next_acc     = '0;
			next_d_prev  = '0;
			next_p_term  = '0;
			next_d_term  = '0;
			next_i_term  = '0;
			next_pid_out = '0;
			next_freq    = '0;
		end else begin
			if (!cfg.rev_allow && (freq < 0 || pid_out < 0)) begin
				next_freq    = '0;
				next_pid_out = '0;
			end
			case (state)
				ST_IDLE: begin
					if (tick) begin
						next_acc       = (cfg.ti == 10'h000) ? '0 : clampw(acc_sum, acc_lim);
						next_p_term    = pidc_wide_t'(cfg.kp) * err_w / pidc_wide_t'(GAIN_DIV);
						next_d_term    = pidc_wide_t'(cfg.td) * pidc_wide_t'(TD_SCALE) * (d_in - pidc_wide_t'(d_prev));
						next_d_prev    = pidc_pct_t'(d_in);
						next_acc_neg   = next_acc < 0;
						next_div_num   = DIV_W'(next_acc < 0 ? -next_acc : next_acc);
						next_div_den   = DIV_W'(pidc_wide_t'(cfg.ti) * pidc_wide_t'(TI_SCALE));
						next_div_start = 1'b1;
						next_state     = ST_DIV;
					end
				end
				ST_DIV: begin
					if (div_bus.done) begin
						next_i_term = pidc_wide_t'(div_bus.quotient);
						if (cfg.ti == 10'h000) begin
							next_i_term = '0;
						end else if (acc_neg) begin
							next_i_term = -pidc_wide_t'(div_bus.quotient);
						end
						next_state = ST_OUT;
					end
				end
				ST_OUT: begin
					if (cfg.mode[MODE_NEG]) begin
						sum = -sum;
					end
					sum = clampw(sum, pidc_wide_t'(cfg.olim));
					if (!cfg.rev_allow && sum < 0) begin
						sum = '0;
					end
					next_pid_out = pidc_pct_t'(sum);
					fref = sum + pidc_wide_t'(cfg.bias) * pidc_wide_t'(cfg.ogain) / pidc_wide_t'(OGAIN_DIV);
					if (cfg.mode[MODE_ADDT] && drive_run_i) begin
						fref = fref + pidc_wide_t'(sp_ramp);
					end
					fref = clampw(fref, pidc_wide_t'(PCT_FULL));
					if (!cfg.rev_allow && fref < 0) begin
						fref = '0;
					end
					next_freq  = pidc_freq_t'(fref * pidc_wide_t'(cfg.fmax) / pidc_wide_t'(PCT_FULL));
					next_state = ST_IDLE;
				end
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			acc       <= '0;
			p_term    <= '0;
			d_term    <= '0;
			i_term    <= '0;
			d_prev    <= '0;
			pid_out   <= '0;
			freq      <= '0;
			div_start <= 1'b0;
			acc_neg   <= 1'b0;
			div_num   <= '0;
			div_den   <= '0;
		end else begin
			state     <= next_state;
			acc       <= next_acc;
			p_term    <= next_p_term;
			d_term    <= next_d_term;
			i_term    <= next_i_term;
			d_prev    <= next_d_prev;
			pid_out   <= next_pid_out;
			freq      <= next_freq;
			div_start <= next_div_start;
			acc_neg   <= next_acc_neg;
			div_num   <= next_div_num;
			div_den   <= next_div_den;
		end
	end

	assign freq_ref_o              = freq;
	assign source_conflict_alarm_o = alarm;
	assign pid_active_o            = cfg.mode[MODE_EN];
endmodule : pidc_top
`default_nettype wire

// ===== testbench/pidc_sensor.sv
// analog sensor model feeding the two controller inputs
`timescale 1ns/1ps
`default_nettype none
module pidc_sensor #(
	parameter int unsigned AIN_W = 12
) (
	input  wire logic             clock_i,
	input  wire logic [AIN_W-1:0] level_one_i,
	input  wire logic [AIN_W-1:0] level_two_i,
	output logic      [AIN_W-1:0] ain_one_o,
	output logic      [AIN_W-1:0] ain_two_o
);
	// converters deliver one fresh sample per clock
	always_ff @(posedge clock_i) begin
		ain_one_o <= level_one_i;
		ain_two_o <= level_two_i;
	end
endmodule : pidc_sensor
`default_nettype wire

// ===== testbench/pidc_top_sva.sv
// port checker for the process controller
`timescale 1ns/1ps
`default_nettype none
module pidc_top_sva import pidc_pkg::*; #(
	parameter int unsigned AIN_W           = 12,
	parameter int unsigned CTRL_PERIOD_CYC = 200
) (
	input wire logic             clock_i,
	input wire logic             resetn_i,
	input wire logic [7:0]       avs_address_i,
	input wire logic             avs_read_i,
	input wire logic             avs_write_i,
	input wire logic [31:0]      avs_writedata_i,
	input wire logic [3:0]       avs_byteenable_i,
	input wire logic [31:0]      avs_readdata_o,
	input wire logic             avs_waitrequest_o,
	input wire logic [AIN_W-1:0] analog_input_one_i,
	input wire logic [AIN_W-1:0] analog_input_two_i,
	input wire logic [9:0]       keypad_setpoint_i,
	input wire logic             drive_run_i,
	input wire pidc_freq_t       freq_ref_o,
	input wire logic             source_conflict_alarm_o,
	input wire logic             pid_active_o
);
	logic wr_done;
	logic src_wr;
	logic cfl;
	logic en_q;
	logic rev_q;
	assign wr_done = avs_write_i && !avs_waitrequest_o;
	assign src_wr  = wr_done && avs_address_i[7:2] == REG_SRC[7:2];
	assign cfl     = (avs_writedata_i[5:4] == 2'h1 || avs_writedata_i[5:4] == 2'h2)
		&& avs_writedata_i[2:0] == {1'b0, avs_writedata_i[5:4]};
	// shadow of the mode register bits that the ports reveal
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_q  <= 1'b0;
			rev_q <= 1'b0;
		end else if (wr_done && avs_address_i[7:2] == REG_MODE[7:2]) begin
			en_q  <= avs_writedata_i[MODE_EN];
			rev_q <= avs_writedata_i[FLD_REV];
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
		else $error("no wait cycle on new request");
	wait_once_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("more than one wait cycle");
	unmapped_read_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[7:2] > REG_FREQ[7:2]
		|-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
	conflict_set_a: assert property (src_wr && cfl |=> source_conflict_alarm_o)
		else $error("conflict alarm missing");
	conflict_clr_a: assert property (src_wr && !cfl |=> !source_conflict_alarm_o)
		else $error("alarm not cleared");
	alarm_hold_a: assert property (!src_wr |=> $stable(source_conflict_alarm_o))
		else $error("alarm moved without source write");
	enable_bit_a: assert property (pid_active_o == en_q)
		else $error("active flag differs from mode bit");
	off_zero_a: assert property (!pid_active_o && $past(!pid_active_o) |-> freq_ref_o == '0)
		else $error("output while disabled");
	no_reverse_a: assert property (!rev_q && $past(!rev_q) |-> !freq_ref_o[17])
		else $error("negative output with reverse blocked");
endmodule : pidc_top_sva
bind pidc_top pidc_top_sva #(.AIN_W(AIN_W), .CTRL_PERIOD_CYC(CTRL_PERIOD_CYC)) chk (.clock_i(clock_i),
	.resetn_i(resetn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .analog_input_one_i(analog_input_one_i),
	.analog_input_two_i(analog_input_two_i), .keypad_setpoint_i(keypad_setpoint_i), .drive_run_i(drive_run_i),
	.freq_ref_o(freq_ref_o), .source_conflict_alarm_o(source_conflict_alarm_o), .pid_active_o(pid_active_o));
`default_nettype wire

// ===== testbench/pidc_top_bench.sv
// self-checking bench of the process controller
`timescale 1ns/1ps
`default_nettype none
module pidc_top_bench;
	import pidc_pkg::*;
	localparam int unsigned PER = 200;
	logic        clock_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [7:0]  avs_address_i = 8'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [11:0] lv1 = 12'h000;
	logic [11:0] lv2 = 12'hfff;
	logic [11:0] ain1;
	logic [11:0] ain2;
	logic [9:0]  keypad = 10'h000;
	logic        drive_run = 1'b0;
	pidc_freq_t  freq;
	logic        alarm;
	logic        active;
	int          n_mismatch = 0;
	int          checks_done = 0;
	logic [7:0]  ra[7] = '{REG_SRC, REG_MODE, REG_KP, REG_TI, REG_FMAX, REG_FBGAIN, 8'h40};
	logic [31:0] rv[7] = '{32'h0000_0021, 32'h0000_0000, 32'h0000_0064, 32'h0000_000a, 32'h0000_1770,
		32'h0000_0064, 32'h0000_0000};
	always #5 clock_i = ~clock_i;
	pidc_sensor #(.AIN_W(12)) sensor (.clock_i(clock_i), .level_one_i(lv1), .level_two_i(lv2),
		.ain_one_o(ain1), .ain_two_o(ain2));
	pidc_top #(.AIN_W(12), .CTRL_PERIOD_CYC(PER)) dut (.clock_i(clock_i), .resetn_i(resetn_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .analog_input_one_i(ain1), .analog_input_two_i(ain2),
		.keypad_setpoint_i(keypad), .drive_run_i(drive_run), .freq_ref_o(freq),
		.source_conflict_alarm_o(alarm), .pid_active_o(active));
	////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address_i   <= a;
		avs_writedata_i <= d;
		avs_write_i     <= we;
		avs_read_i      <= !we;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		q = avs_readdata_o;
		if (n >= 20) n_mismatch++;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
		@(posedge clock_i);
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0000_0000, q);
		checks_done++;
		if (q !== e) begin
			n_mismatch++;
			$display("BAD reg %h expected %h seen %h", a, e, q);
		end
	endtask : rdc
	task automatic fchk(input pidc_freq_t e);
		repeat (3 * PER) @(posedge clock_i);
		checks_done++;
		if (freq !== e) begin
			n_mismatch++;
			$display("BAD freq_ref expected %0d seen %0d", e, freq);
		end
	endtask : fchk
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch++;
		results();
	end
	initial begin
		repeat (3) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		foreach (ra[i]) rdc(ra[i], rv[i]);
		wr(REG_SRC, 32'h0000_0011);
		rdc(REG_SRC, 32'h0000_0021);
		rdc(REG_STATUS, 32'h0000_0001);
		wr(REG_SRC, 32'h0000_0014);
		rdc(REG_STATUS, 32'h0000_0000);
		wr(REG_TARGET, 32'h0000_07d0);
		rdc(REG_TARGET, 32'h0000_03e8);
		wr(REG_TARGET, 32'h0000_01f4);
		wr(REG_TI, 32'h0000_0000);
		wr(REG_MODE, 32'h0000_0001);
		fchk(18'sd3000);
		lv1 <= 12'h800;
		fchk(18'sd0);
		lv1 <= 12'h000;
		wr(REG_KP, 32'h0000_00c8);
		wr(REG_OLIM, 32'h0000_0320);
		fchk(18'sd4800);
		wr(REG_MODE, 32'h0000_0003);
		fchk(18'sd0);
		wr(REG_MODE, 32'h0000_0013);
		fchk(-18'sd4800);
		wr(REG_MODE, 32'h0000_0011);
		wr(REG_KP, 32'h0000_0064);
		wr(REG_OLIM, 32'h0000_03e8);
		wr(REG_SRC, 32'h0000_0012);
		fchk(18'sd6000);
		lv1 <= 12'h800;
		keypad <= 10'h2bc;
		wr(REG_SRC, 32'h0000_0110);
		fchk(18'sd1200);
		wr(REG_SRC, 32'h0000_0010);
		fchk(-18'sd3000);
		wr(REG_SRC, 32'h0000_0014);
		wr(REG_MODE, 32'h0000_0019);
		drive_run <= 1'b1;
		fchk(18'sd3000);
		drive_run <= 1'b0;
		fchk(18'sd0);
		wr(REG_MODE, 32'h0000_0011);
		wr(REG_BIAS, 32'h0000_0064);
		wr(REG_OGAIN, 32'h0000_0014);
		fchk(18'sd1200);
		wr(REG_MODE, 32'h0000_0010);
		fchk(18'sd0);
		lv1 <= 12'h000;
		wr(REG_KP, 32'h0000_0000);
		wr(REG_BIAS, 32'h0000_0000);
		wr(REG_ILIM, 32'h0000_0005);
		wr(REG_TI, 32'h0000_0001);
		wr(REG_MODE, 32'h0000_0011);
		fchk(18'sd30);
		rdc(REG_PIDOUT, 32'h0000_0005);
		rdc(REG_FREQ, 32'h0000_001e);
		results();
	end
endmodule : pidc_top_bench
`default_nettype wire
